// ---- include/hpoe_pkg.sv ----
`default_nettype none
package hpoe_pkg;

  // Register index as printed; 0x5A is not a multiple of four, so byte address is four times it.
  localparam logic [7:0]  HPOE_STAGE_IDX      = 8'h5A;
  localparam logic [9:0]  HPOE_STAGE_ADDR     = {HPOE_STAGE_IDX, 2'b00};
  localparam logic [7:0]  HPOE_STAGE_RESET    = 8'h00;

  // Field positions inside the stage enable register.
  localparam int unsigned HPOE_BIT_R_IN       = 0;
  localparam int unsigned HPOE_BIT_R_MID      = 1;
  localparam int unsigned HPOE_BIT_R_OUT      = 2;
  localparam int unsigned HPOE_BIT_R_SHORT    = 3;
  localparam int unsigned HPOE_BIT_L_IN       = 4;
  localparam int unsigned HPOE_BIT_L_MID      = 5;
  localparam int unsigned HPOE_BIT_L_OUT      = 6;
  localparam int unsigned HPOE_BIT_L_SHORT    = 7;

  // Least gap the host should leave between input and intermediate stage enables.
  localparam int unsigned HPOE_MID_GAP_NS     = 20000;
  localparam int unsigned HPOE_CLK_PERIOD_NS  = 4;
  localparam int unsigned HPOE_MID_GAP_CYC    = (HPOE_MID_GAP_NS + HPOE_CLK_PERIOD_NS - 1) / HPOE_CLK_PERIOD_NS;

endpackage : hpoe_pkg
`default_nettype wire

// ---- hw/hpoe_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

module hpoe_ctrl
  import hpoe_pkg::*;
(
  // Clock, reset and the APB request from the host.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  // APB answer, registered.
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog stage controls, each from a flip-flop, in register bit order.
  output logic             left_short_release,
  output logic             left_out_stage_on,
  output logic             left_mid_stage_on,
  output logic             left_in_stage_on,
  output logic             right_short_release,
  output logic             right_out_stage_on,
  output logic             right_mid_stage_on,
  output logic             right_in_stage_on
);

  logic [7:0]  stage_q;    // Stage enable register contents.
  logic [7:0]  stage_d;    // Next value of the stage enable register.
  logic [31:0] prdata_d;   // Read data presented in the access phase.
  logic        pready_d;   // Ready is raised for the access phase only.
  logic        pslverr_d;  // Error flag for unmapped addresses.
  logic        hit;        // The address selects the stage register.
  logic        setup;      // A setup cycle is under way.
  logic        wr_commit;  // A write to the stage register completes at this edge.
  logic [7:0]  pin_vec;    // Stage pins gathered in register bit order, for the checks.

  // Decode the address and note setup cycles; upper address bits must be zero.
  assign hit   = (paddr == {2'b00, HPOE_STAGE_ADDR});
  assign setup = psel && !penable;

  // A write lands only on the completing access edge, and only with lane 0 strobed; a cleared
  // strobe leaves the register alone so that writes aimed at other lanes cannot upset the stages.
  assign wr_commit = psel && penable && pready && hit && pwrite && pstrb[0];

  // Stage pins gathered in register bit order for the checks below.
  assign pin_vec = {left_short_release, left_out_stage_on, left_mid_stage_on, left_in_stage_on,
                    right_short_release, right_out_stage_on, right_mid_stage_on, right_in_stage_on};

  // Work out the next register value and the bus answer.
  always_comb
  begin
    stage_d   = stage_q;
    prdata_d  = 32'h0000_0000;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    // Each transfer answers in its first access cycle, so the setup cycle prepares the answer.
    if (setup)
    begin
      pready_d  = 1'b1;
      // Any address but the stage register is refused, and a write there is dropped.
      pslverr_d = !hit;
      // Reads of the stage register return the bits last written, upper bits zero.
      if (hit && !pwrite)
      begin
        prdata_d = {24'h00_0000, stage_q};
      end
    end
    // The write lands at the completing access edge; lane 0 carries the byte.
    // Upper lanes of the write data are ignored, since the register is one byte wide.
    if (wr_commit)
    begin
      stage_d = pwdata[7:0];
    end
  end

  // Register the stage bits and the bus answer.
  // Ready is registered, so every transfer has exactly one access cycle and no wait state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // All bits clear, so the stages start powered down with both shorts applied.
      stage_q <= HPOE_STAGE_RESET;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      stage_q <= stage_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // Drive each analog stage control from its own flip-flop copy of the register bit.
  // The copies load the same next value as the register, so pins and register never disagree,
  // and the analog side sees no decode glitches.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Every stage starts off and both shorts stay applied.
      left_short_release  <= 1'b0;
      left_out_stage_on   <= 1'b0;
      left_mid_stage_on   <= 1'b0;
      left_in_stage_on    <= 1'b0;
      right_short_release <= 1'b0;
      right_out_stage_on  <= 1'b0;
      right_mid_stage_on  <= 1'b0;
      right_in_stage_on   <= 1'b0;
    end
    else
    begin
      left_short_release  <= stage_d[HPOE_BIT_L_SHORT];
      left_out_stage_on   <= stage_d[HPOE_BIT_L_OUT];
      left_mid_stage_on   <= stage_d[HPOE_BIT_L_MID];
      left_in_stage_on    <= stage_d[HPOE_BIT_L_IN];
      right_short_release <= stage_d[HPOE_BIT_R_SHORT];
      right_out_stage_on  <= stage_d[HPOE_BIT_R_OUT];
      right_mid_stage_on  <= stage_d[HPOE_BIT_R_MID];
      right_in_stage_on   <= stage_d[HPOE_BIT_R_IN];
    end
  end

  // A write to the register reaches every stage output at the completing edge.
  property write_lands_p;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && hit && pstrb[0]) |=>
      ({left_short_release, left_out_stage_on, left_mid_stage_on, left_in_stage_on,
        right_short_release, right_out_stage_on, right_mid_stage_on, right_in_stage_on}
       == $past(pwdata[7:0]));
  endproperty
  write_land_a: assert property (write_lands_p) else $error("Stage outputs differ from write data.");

  // Each stage pin takes its bit of a committed write at the completing edge and holds it between writes.
  // The expected value comes from the write data, not from the register, so a swapped or stuck
  // bit is caught even though pins and register share one next value.
  // Right input stage follows bit 0.
  right_in_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    right_in_stage_on == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_R_IN]) : $past(right_in_stage_on)))
    else $error("Right input stage mismatch.");
  // Right intermediate stage follows bit 1.
  right_mid_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    right_mid_stage_on == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_R_MID]) : $past(right_mid_stage_on)))
    else $error("Right intermediate stage mismatch.");
  // Right output stage follows bit 2.
  right_out_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    right_out_stage_on == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_R_OUT]) : $past(right_out_stage_on)))
    else $error("Right output stage mismatch.");
  // Right short release follows bit 3.
  right_short_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    right_short_release == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_R_SHORT]) : $past(right_short_release)))
    else $error("Right short release mismatch.");
  // Left input stage follows bit 4.
  left_in_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    left_in_stage_on == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_L_IN]) : $past(left_in_stage_on)))
    else $error("Left input stage mismatch.");
  // Left intermediate stage follows bit 5.
  left_mid_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    left_mid_stage_on == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_L_MID]) : $past(left_mid_stage_on)))
    else $error("Left intermediate stage mismatch.");
  // Left output stage follows bit 6.
  left_out_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    left_out_stage_on == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_L_OUT]) : $past(left_out_stage_on)))
    else $error("Left output stage mismatch.");
  // Left short release follows bit 7.
  left_short_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    left_short_release == ($past(wr_commit) ? $past(pwdata[HPOE_BIT_L_SHORT]) : $past(left_short_release)))
    else $error("Left short release mismatch.");

  // Transfer steps: a setup cycle, then the one access cycle that carries the answer.
  sequence setup_s;
    psel && !penable;
  endsequence
  // A read setup cycle on the stage register.
  sequence read_setup_s;
    psel && !penable && !pwrite && hit;
  endsequence
  // A setup cycle on any address other than the stage register.
  sequence stray_setup_s;
    psel && !penable && !hit;
  endsequence
  // The refusal: ready with the error flag and no data.
  sequence refusal_s;
    pready && pslverr && (prdata == 32'h0000_0000);
  endsequence

  // Every setup cycle is answered in the very next cycle.
  ready_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_s |=> pready)
    else $error("No answer in the first access cycle.");
  // Ready stands for one cycle only, so a held access phase cannot commit twice.
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready held longer than one cycle.");
  // A read of the register, one cycle after setup, returns the stage pins as they stood.
  read_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_setup_s |=> (pready && !pslverr && prdata == {24'h00_0000, $past(pin_vec)}))
    else $error("Read data differs from register.");
  // An access to any other address is refused with an error and empty data.
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    stray_setup_s |=> refusal_s)
    else $error("Unmapped access not refused.");

endmodule : hpoe_ctrl
`default_nettype wire

// ---- test/test_hpoe_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
// Drives the stage enable register over APB and checks the stage pins and the read back value.
module test_hpoe_ctrl
  import hpoe_pkg::*;
();
  logic        pclk;          // Bus clock, 4 ns period.
  logic        presetn;       // Active low reset.
  logic        psel;          // Select.
  logic        penable;       // Access phase.
  logic        pwrite;        // Direction.
  logic [11:0] paddr;         // Byte address.
  logic [31:0] pwdata;        // Write data.
  logic [3:0]  pstrb;         // Byte strobes.
  logic [31:0] prdata;        // Read data.
  logic        pready;        // Answer.
  logic        pslverr;       // Error answer.
  logic [31:0] rd;            // Last read data taken.
  logic        err;           // Last error flag taken.
  wire  logic [7:0] pins;     // Stage pins, bit order as in the register.
  int          miscompares = 0;
  int          checks = 0;
  localparam logic [11:0] REG_A = {2'h0, HPOE_STAGE_ADDR};

  hpoe_ctrl u_hpoe_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .left_short_release(pins[7]), .left_out_stage_on(pins[6]), .left_mid_stage_on(pins[5]),
    .left_in_stage_on(pins[4]), .right_short_release(pins[3]), .right_out_stage_on(pins[2]),
    .right_mid_stage_on(pins[1]), .right_in_stage_on(pins[0]));

  // Free running clock.
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("Counts: checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Compares a value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Just after a rising edge the registered outputs still show what that edge sampled.
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      close_out();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Writes with junk in the upper lanes, reads back and checks pins.
  task automatic wrrd(input logic [7:0] v, input logic [3:0] s, input logic [7:0] exp);
    apb(1'b1, REG_A, {24'hA5A5A5, v}, s);
    apb(1'b0, REG_A, 32'h0, 4'hF);
    chk(rd, {24'h0, exp});
    chk({24'h0, pins}, {24'h0, exp});
  endtask : wrrd

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_A, 32'h0, 4'hF);
    chk(rd, {24'h0, HPOE_STAGE_RESET});
    chk({31'h0, err}, 32'h0);
    $display("Test reset value done");
    for (int i = 0; i < 8; i++)
      wrrd(8'h01 << i, 4'hF, 8'h01 << i);
    $display("Test walking bits done");
    wrrd(8'h11, 4'hF, 8'h11);
    repeat (HPOE_MID_GAP_CYC) @(posedge pclk);
    wrrd(8'h33, 4'hF, 8'h33);
    wrrd(8'h77, 4'hF, 8'h77);
    wrrd(8'hFF, 4'hF, 8'hFF);
    $display("Test bring up done");
    apb(1'b1, REG_A + 12'h004, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1);
    chk({24'h0, pins}, 32'h0000_00FF);
    wrrd(8'h00, 4'hE, 8'hFF);
    $display("Test refused writes done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({24'h0, pins}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, REG_A, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    wrrd(8'h5A, 4'h1, 8'h5A);
    $display("Test mid run reset done");
    close_out();
  end
endmodule : test_hpoe_ctrl
`default_nettype wire
